// File: design/dmb_defs.svh
`ifndef DMB_DEFS_SVH
`define DMB_DEFS_SVH

// banked special function register window
`define DMB_SFR_BANK_LO 8'h10
`define DMB_SFR_BANK_HI 8'h17
// end of the special function register area
`define DMB_SFR_TOP 8'h1F
// where the bank select register sits, unbanked
`define DMB_BSR_ADDR 8'h0F
`define DMB_BSR_RESET 4'h0
// one bit per peripheral bank: banks 0..3 present
`define DMB_PBANK_IMPL 16'h000F
// one bit per ram bank: banks 0..3 present
`define DMB_RBANK_IMPL 16'h000F
`define DMB_PBANK_RSVD 4'hF
`define DMB_NIB_LO 3:0
`define DMB_NIB_HI 7:4
`define DMB_ZERO_BYTE 8'h00
`define DMB_ZERO_NIB 4'h0

`endif

// File: design/dmb_pkg.sv
package dmb_pkg;

    // one data memory access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmb_req_s;

    // access as routed to registers or ram
    typedef struct packed {
        logic rd;
        logic wr;
        logic sfr;
        logic [3:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmb_acc_s;

    typedef enum logic [1:0] {
        DMB_RD_TARGET = 2'b00,
        DMB_RD_ZERO = 2'b01,
        DMB_RD_BSR = 2'b10
    } dmb_rdsrc_e;

endpackage : dmb_pkg

// File: design/dmb_nibble_reg.sv
`timescale 1ns/1ns
`include "dmb_defs.svh"

module dmb_nibble_reg #(
    parameter bit IMPL = 1'b1
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [3:0] wdata_i,
    input wire logic ld_i,
    input wire logic [3:0] lit_i,
    output logic [3:0] q_o
);

    logic [3:0] q;
    wire [3:0] next_q = ld_i ? lit_i : (wr_i ? wdata_i : q);

    generate
        if (IMPL) begin : g_impl
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) q <= `DMB_BSR_RESET;
                else q <= next_q;
            end
        end else begin : g_none
            // absent nibble: no storage, reads as zero
            always_comb q = `DMB_ZERO_NIB;
        end
    endgenerate

    assign q_o = q;

endmodule : dmb_nibble_reg

// File: design/dmb_bank_select.sv
`timescale 1ns/1ns
`include "dmb_defs.svh"

module dmb_bank_select
    import dmb_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire dmb_req_s req_i,
    input wire logic load_peripheral_bank_literal_i,
    input wire logic load_ram_bank_literal_i,
    input wire logic [3:0] bank_literal_i,
    input wire logic [7:0] target_rdata_i,
    output dmb_acc_s acc_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_discard_o,
    output logic [7:0] bank_select_register_o
);

    logic [3:0] pbank;
    logic [3:0] rbank;
    dmb_acc_s acc;
    logic [7:0] rd_data;
    logic rd_valid;
    logic wr_discard;
    logic [7:0] bsr_q;
    logic acc_rd_pend;
    dmb_rdsrc_e rdsrc;
    dmb_rdsrc_e next_rdsrc;
    logic [7:0] next_rd_data;

    // address decode
    wire [7:0] addr = req_i.addr;
    wire is_bsr = addr == `DMB_BSR_ADDR;
    wire at_or_above_lo = addr >= `DMB_SFR_BANK_LO;
    wire at_or_below_hi = addr <= `DMB_SFR_BANK_HI;
    wire is_banked = at_or_above_lo && at_or_below_hi;
    wire is_sfr = addr <= `DMB_SFR_TOP;
    wire is_ram = !is_sfr;
    wire is_plain_sfr = is_sfr && !is_banked;

    // bank presence
    wire [15:0] pimpl_mask = `DMB_PBANK_IMPL;
    wire [15:0] rimpl_mask = `DMB_RBANK_IMPL;
    wire pbank_ok = pimpl_mask[pbank];
    wire pbank_rsvd = pbank == `DMB_PBANK_RSVD;
    wire rbank_ok = rimpl_mask[rbank];

    // absent banks read as zero; the reserved bank passes whatever answers
    wire banked_dead = is_banked && !pbank_ok && !pbank_rsvd;
    wire ram_dead = is_ram && !rbank_ok;
    wire any_dead = banked_dead || ram_dead;

    // writes never land in an absent or reserved bank
    wire banked_nowr = is_banked && (!pbank_ok || pbank_rsvd);
    wire drop_wr = req_i.wr && (banked_nowr || ram_dead);
    wire bsr_wr = req_i.wr && is_bsr;

    // unbanked sfr addresses carry bank zero whatever the peripheral bank
    wire [3:0] sfr_bank = is_plain_sfr ? `DMB_ZERO_NIB : pbank;
    wire [3:0] sel_bank = is_ram ? rbank : sfr_bank;

    // routed access
    wire acc_rd_ok = req_i.rd && !is_bsr && !any_dead;
    wire acc_wr_ok = req_i.wr && !is_bsr && !drop_wr;

    always_comb begin
        acc.rd = acc_rd_ok;
        acc.wr = acc_wr_ok;
        acc.sfr = is_sfr;
        acc.bank = sel_bank;
        acc.addr = addr;
        acc.wdata = req_i.wdata;
    end

    // source of the read answer, fixed when the request is taken
    always_comb begin
        next_rdsrc = DMB_RD_TARGET;
        if (is_bsr) begin
            next_rdsrc = DMB_RD_BSR;
        end else if (any_dead) begin
            next_rdsrc = DMB_RD_ZERO;
        end else begin
            next_rdsrc = DMB_RD_TARGET;
        end
    end

    // small variants ignore the ram bank load
    wire ld_rbank = load_ram_bank_literal_i && LARGE;

    // bank nibbles; the low one always exists, the high one only when large
    dmb_nibble_reg #(.IMPL(1'b1)) u_pbank (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bsr_wr),
        .wdata_i(req_i.wdata[`DMB_NIB_LO]),
        .ld_i(load_peripheral_bank_literal_i),
        .lit_i(bank_literal_i),
        .q_o(pbank)
    );

    dmb_nibble_reg #(.IMPL(LARGE)) u_rbank (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bsr_wr),
        .wdata_i(req_i.wdata[`DMB_NIB_HI]),
        .ld_i(ld_rbank),
        .lit_i(bank_literal_i),
        .q_o(rbank)
    );

    // bank select reads back the stored bits; the high nibble is zero when small
    wire [3:0] bsr_lo = pbank;
    wire [3:0] bsr_hi = rbank;
    wire [7:0] bsr_now = {bsr_hi, bsr_lo};

    // the target answers in the same cycle acc_o goes out, so the source is registered alongside acc_o
    always_comb begin
        case (rdsrc)
            DMB_RD_BSR: begin
                next_rd_data = bsr_q;
            end
            DMB_RD_ZERO: begin
                next_rd_data = `DMB_ZERO_BYTE;
            end
            DMB_RD_TARGET: begin
                next_rd_data = target_rdata_i;
            end
            default: begin
                next_rd_data = `DMB_ZERO_BYTE;
            end
        endcase
    end
    wire [7:0] rd_answer = acc_rd_pend ? next_rd_data : `DMB_ZERO_BYTE;

    // stage 1: route the access with the bank value held before this cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            acc_o <= '0;
        end else begin
            acc_o <= acc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdsrc <= DMB_RD_TARGET;
        end else begin
            rdsrc <= next_rdsrc;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            acc_rd_pend <= 1'b0;
        end else begin
            acc_rd_pend <= req_i.rd;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bsr_q <= `DMB_ZERO_BYTE;
        end else begin
            bsr_q <= bsr_now;
        end
    end

    // a dropped write is only flagged; status flags stay with the core
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wr_discard <= 1'b0;
        end else begin
            wr_discard <= drop_wr;
        end
    end

    // stage 2: read answer back to the core
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rd_data <= `DMB_ZERO_BYTE;
        end else begin
            rd_data <= rd_answer;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= acc_rd_pend;
        end
    end

    // copy trails the register by one cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bank_select_register_o <= `DMB_ZERO_BYTE;
        end else begin
            bank_select_register_o <= bsr_now;
        end
    end

    assign rd_data_o = rd_data;
    assign rd_valid_o = rd_valid;
    assign wr_discard_o = wr_discard;

endmodule : dmb_bank_select

// File: tb/dmb_bank_select_checker.sv
`timescale 1ns/1ns
module dmb_bank_select_checker
    import dmb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire dmb_req_s req_i,
    input wire logic load_peripheral_bank_literal_i,
    input wire logic load_ram_bank_literal_i,
    input wire logic [3:0] bank_literal_i,
    input wire logic [7:0] target_rdata_i,
    input wire dmb_acc_s acc_o,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic wr_discard_o,
    input wire logic [7:0] bank_select_register_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    wire lp = load_peripheral_bank_literal_i;
    wire lr = load_ram_bank_literal_i;
    wire bnk = req_i.rd && req_i.addr inside {[8'h10:8'h17]};
    property p_zero; req_i.rd && req_i.addr != 8'h0F ##1 !acc_o.rd |=> rd_data_o == 8'h00; endproperty
    property p_pass; acc_o.rd |=> rd_valid_o && rd_data_o == $past(target_rdata_i); endproperty
    property p_drop; wr_discard_o |-> $past(req_i.wr) && !acc_o.wr; endproperty
    property p_unb; req_i.rd && req_i.addr < 8'h0F |=> acc_o.rd && acc_o.sfr && acc_o.bank == 4'h0;
    endproperty
    property p_lp; lp |-> ##2 bank_select_register_o[3:0] == $past(bank_literal_i, 2); endproperty
    property p_lr; lr && !lp |-> ##2 bank_select_register_o[7:4] == $past(bank_literal_i, 2); endproperty
    property p_nxt; lp && !req_i.wr ##1 bnk |=> acc_o.bank == $past(bank_literal_i, 2); endproperty
    property p_ram; lr && !lp && !req_i.wr ##1 req_i.rd && req_i.addr > 8'h1F
        |=> !acc_o.sfr && acc_o.bank == $past(bank_literal_i, 2); endproperty
    a_zero: assert property (p_zero) else $error("absent bank read not zero");
    a_pass: assert property (p_pass) else $error("read data not passed");
    a_drop: assert property (p_drop) else $error("discard without write");
    a_unb: assert property (p_unb) else $error("unbanked decode wrong");
    a_lp: assert property (p_lp) else $error("peripheral load lost");
    a_lr: assert property (p_lr) else $error("ram load lost");
    a_nxt: assert property (p_nxt) else $error("bank change late");
    a_ram: assert property (p_ram) else $error("ram bank wrong");
    c_drop: cover property (wr_discard_o);
    c_zero: cover property (rd_valid_o && rd_data_o == 8'h00);
    c_wr: cover property (acc_o.wr);
endmodule : dmb_bank_select_checker

// File: tb/dmb_mem_model.sv
`timescale 1ns/1ns
module dmb_mem_model
    import dmb_pkg::*;
(
    input wire logic mclk_i,
    input wire dmb_acc_s acc_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [4096];
    // idle bus shows inverted data, not a stale copy
    assign rdata_o = acc_i.rd ? mem[{acc_i.bank, acc_i.addr}] : ~mem[{acc_i.bank, acc_i.addr}];
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'hC3;
    end
    always @(posedge mclk_i) begin
        if (acc_i.wr) mem[{acc_i.bank, acc_i.addr}] <= acc_i.wdata;
    end
endmodule : dmb_mem_model

// File: tb/dmb_bank_select_test.sv
`timescale 1ns/1ns
module dmb_bank_select_test
    import dmb_pkg::*;
;
    logic clk, rst, lp, lr, v, rv, dsc, rvs;
    logic [3:0] lit;
    logic [7:0] td, q, bank_select, rq;
    dmb_req_s req;
    dmb_acc_s acc;
    int bad_count, compares;
    dmb_bank_select DUT (.mclk_i(clk), .sys_rst_i(rst), .req_i(req),
        .load_peripheral_bank_literal_i(lp), .load_ram_bank_literal_i(lr),
        .bank_literal_i(lit), .target_rdata_i(td), .acc_o(acc), .rd_data_o(q),
        .rd_valid_o(rv), .wr_discard_o(v), .bank_select_register_o(bank_select));
    dmb_mem_model u_mem (.mclk_i(clk), .acc_i(acc), .rdata_o(td));
    task summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // load is taken at the edge where the next op drives its request
    task ld(input logic p, input logic [3:0] d);
        @(posedge clk);
        lp <= p;
        lr <= !p;
        lit <= d;
    endtask : ld
    task op(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{r, !r, a, d};
        lp <= 1'b0;
        lr <= 1'b0;
        @(posedge clk);
        req <= '0;
        #1 dsc = v;
        @(posedge clk);
        #1 rq = q;
        rvs = rv;
    endtask : op
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000 bad_count++;
        summarize;
    end
    initial begin
        {rst, lp, lr, lit, req} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(bank_select, 8'h00);
        ld(1, 2); ld(0, 3); op(0, 8'h12, 8'h5A);
        chk({7'h0, rvs}, 8'h00);
        chk({7'h0, dsc}, 8'h00);
        ld(1, 2); op(1, 8'h12, 0); chk(rq, 8'h5A);
        chk({7'h0, rvs}, 8'h01);
        ld(1, 13); op(0, 8'h12, 8'h77); chk({7'h0, dsc}, 8'h01);
        op(1, 8'h12, 0); chk(rq, 8'h00);
        chk({7'h0, rvs}, 8'h01);
        ld(1, 15); op(0, 8'h12, 8'h66); chk({7'h0, dsc}, 8'h01);
        op(0, 8'h05, 8'h11); ld(1, 0); op(1, 8'h05, 0); chk(rq, 8'h11);
        op(0, 8'h40, 8'h3C); ld(0, 5); op(1, 8'h40, 0); chk(rq, 8'h00);
        ld(0, 3); op(1, 8'h40, 0); chk(rq, 8'h3C);
        op(0, 8'h0F, 8'h31); op(1, 8'h0F, 0); chk(rq, 8'h31);
        chk(bank_select, 8'h31);
        summarize;
    end
endmodule : dmb_bank_select_test
bind dmb_bank_select dmb_bank_select_checker u_chk (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req_i),
    .load_peripheral_bank_literal_i(load_peripheral_bank_literal_i),
    .load_ram_bank_literal_i(load_ram_bank_literal_i),
    .bank_literal_i(bank_literal_i),
    .target_rdata_i(target_rdata_i),
    .acc_o(acc_o),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .wr_discard_o(wr_discard_o),
    .bank_select_register_o(bank_select_register_o)
);
